// [core/remote_pump_run_control.sv]
`timescale 1ns/1ps
`default_nettype none
module remote_pump_run_control #(
  parameter int unsigned MIN_PULSE_CYC = pump_pkg::MIN_PULSE_CYC,
  parameter int unsigned LEVEL_HOLD_CYC = pump_pkg::LEVEL_HOLD_CYC,
  parameter int unsigned GATE_CYC = pump_pkg::GATE_CYC,
  parameter int ADC_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_req_n,
  input wire logic stop_req_n,
  input wire logic remote_sel_n,
  input wire logic flow_pulse_input,
  input wire logic key_down,
  input wire logic key_up,
  input wire logic key_runstop,
  input wire logic [ADC_W-1:0] adc_code,
  input wire logic fault_pressure_high,
  input wire logic fault_pressure_low,
  input wire logic fault_motor_stall,
  output logic motor_run,
  output logic relay_coil,
  output logic display_select,
  output logic display_freq,
  output logic remote_flow_active,
  output logic [15:0] flow_setpoint,
  output logic irq
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [6:0] pins_s;
  logic [6:0] pins_d_reg;
  pin_sync #(.WIDTH(7), .IDLE(pump_pkg::PIN_IDLE)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({key_runstop, key_up, key_down, flow_pulse_input, remote_sel_n,
             stop_req_n, run_req_n}),
    .pin_out(pins_s)
  );
  wire run_low = ~pins_s[0];
  wire stop_low = ~pins_s[1];
  wire remote = ~pins_s[2];
  wire [3:0] rise = pins_s[6:3] & ~pins_d_reg[6:3];
  wire pulse_rise = rise[0];
  wire dn_press = rise[1];
  wire up_press = rise[2];
  wire rs_press = rise[3];

  // ----------------------------------------
  // Low-width counters for run and stop
  // ----------------------------------------
  logic [1:0] fire;
  logic [1:0] held;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_width
      logic [31:0] cnt_reg;
      wire low = ~pins_s[gi];
      wire sat = cnt_reg >= LEVEL_HOLD_CYC;
      assign held[gi] = sat;
      // Fires once per low pulse, exactly at the minimum width
      assign fire[gi] = low && (cnt_reg == MIN_PULSE_CYC - 1);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg <= 32'h0;
        end else if (!low) begin
          cnt_reg <= 32'h0;
        end else if (!sat) begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
    end
  endgenerate
  wire run_fire = fire[0];
  wire stop_fire = fire[1];
  // A stop input held low far beyond a pulse means a jumper to common
  wire level_mode = stop_low && held[1];

  // ----------------------------------------
  // Power-up mode selection
  // ----------------------------------------
  pump_pkg::mode_state_type state_reg;
  pump_pkg::mode_state_type state_next;
  logic [3:0] settle_reg;
  logic freq_mode_reg;
  wire selecting = state_reg == pump_pkg::ST_SELECT;
  wire normal = state_reg == pump_pkg::ST_NORMAL;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pump_pkg::ST_POWERUP: begin
        // Wait for the synchronisers to fill before sampling the key
        if (settle_reg == pump_pkg::SETTLE_CYC) begin
          state_next = pins_s[4] ? pump_pkg::ST_SELECT : pump_pkg::ST_NORMAL;
        end
      end
      pump_pkg::ST_SELECT: begin
        if (rs_press) begin
          state_next = pump_pkg::ST_NORMAL;
        end
      end
      pump_pkg::ST_NORMAL: state_next = pump_pkg::ST_NORMAL;
      default: state_next = pump_pkg::ST_POWERUP;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pump_pkg::ST_POWERUP;
      settle_reg <= 4'h0;
      freq_mode_reg <= 1'b0;
      pins_d_reg <= pump_pkg::PIN_IDLE;
    end else begin
      state_reg <= state_next;
      pins_d_reg <= pins_s;
      if (settle_reg != pump_pkg::SETTLE_CYC) begin
        settle_reg <= settle_reg + 4'h1;
      end
      if (selecting && dn_press) begin
        freq_mode_reg <= ~freq_mode_reg;
      end
    end
  end

  // ----------------------------------------
  // Motor and fault relay
  // ----------------------------------------
  logic motor_reg;
  logic fault_reg;
  logic [2:0] cause_reg;
  wire [2:0] faults = {fault_motor_stall, fault_pressure_low, fault_pressure_high};
  wire fault_evt = motor_reg && (|faults);
  wire key_toggle = normal && rs_press;
  logic motor_next;
  // Fault first, then level input, then stop before run, then the key
  always_comb begin
    if (fault_evt) begin
      motor_next = 1'b0;
    end else if (level_mode) begin
      motor_next = run_low && !fault_reg;
    end else if (stop_fire) begin
      motor_next = 1'b0;
    end else if (run_fire) begin
      motor_next = 1'b1;
    end else if (key_toggle) begin
      motor_next = ~motor_reg;
    end else begin
      motor_next = motor_reg;
    end
  end
  // Level mode holds the fault until the run input is released, else it re-arms
  wire fault_clr = level_mode ? !run_low : (motor_next && !motor_reg);
  wire start_evt = motor_next && !motor_reg;
  wire stop_evt = !motor_next && motor_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_reg <= 1'b0;
      fault_reg <= 1'b0;
      cause_reg <= 3'h0;
    end else begin
      motor_reg <= motor_next;
      if (fault_evt) begin
        fault_reg <= 1'b1;
        cause_reg <= faults;
      end else if (fault_clr) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Flow setpoint
  // ----------------------------------------
  logic head10_reg;
  logic [15:0] panel_flow_reg;
  logic [31:0] gate_cnt_reg;
  logic [15:0] edge_cnt_reg;
  logic [15:0] freq_hz_reg;
  wire [15:0] full = head10_reg ? pump_pkg::FULL_10ML : pump_pkg::FULL_5ML;
  wire panel_keys = normal && !remote;
  wire can_up = panel_flow_reg <= full - pump_pkg::FLOW_STEP;
  wire can_dn = panel_flow_reg >= pump_pkg::FLOW_STEP;
  wire gate_end = gate_cnt_reg == GATE_CYC - 1;
  wire [ADC_W+15:0] adc_prod = adc_code * full;
  wire [15:0] volt_flow = adc_prod[ADC_W+15:ADC_W];
  wire [15:0] freq_flow = (freq_hz_reg > full) ? full : freq_hz_reg;
  wire [15:0] remote_flow = freq_mode_reg ? freq_flow : volt_flow;
  wire [15:0] flow_next = remote ? remote_flow : panel_flow_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_flow_reg <= pump_pkg::FLOW_RESET;
      gate_cnt_reg <= 32'h0;
      edge_cnt_reg <= 16'h0;
      freq_hz_reg <= 16'h0;
    end else begin
      if (panel_keys && up_press && can_up) begin
        panel_flow_reg <= panel_flow_reg + pump_pkg::FLOW_STEP;
      end else if (panel_keys && dn_press && can_dn) begin
        panel_flow_reg <= panel_flow_reg - pump_pkg::FLOW_STEP;
      end
      // One-second gate: edge count equals hertz
      gate_cnt_reg <= gate_end ? 32'h0 : gate_cnt_reg + 32'h1;
      if (gate_end) begin
        freq_hz_reg <= edge_cnt_reg;
        edge_cnt_reg <= {15'h0, pulse_rise};
      end else if (pulse_rise && edge_cnt_reg != 16'hffff) begin
        edge_cnt_reg <= edge_cnt_reg + 16'h1;
      end
    end
  end

  // ----------------------------------------
  // APB registers and interrupt
  // ----------------------------------------
  logic [2:0] int_stat_reg;
  logic [2:0] int_mask_reg;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a == off;
  endfunction : hit
  wire wr_en = psel && penable && pready && pwrite;
  wire setup = psel && !penable;
  wire [2:0] w1c = (wr_en && hit(paddr, pump_pkg::INT_STAT_OFF)) ? pwdata[2:0] : 3'h0;
  wire [2:0] events = {stop_evt, start_evt, fault_evt};
  // Hardware set wins over a same-cycle software clear
  wire [2:0] int_stat_next = (int_stat_reg & ~w1c) | events;
  wire [31:0] status_word = {21'h0, cause_reg, 2'h0, selecting, freq_mode_reg,
                             remote, level_mode, fault_reg, motor_reg};
  wire mapped = hit(paddr, pump_pkg::CTRL_OFF) || hit(paddr, pump_pkg::STATUS_OFF)
             || hit(paddr, pump_pkg::INT_STAT_OFF) || hit(paddr, pump_pkg::INT_MASK_OFF)
             || hit(paddr, pump_pkg::FLOW_OFF) || hit(paddr, pump_pkg::FREQ_OFF);
  wire [31:0] rd_mux =
      hit(paddr, pump_pkg::CTRL_OFF) ? {31'h0, head10_reg} :
      hit(paddr, pump_pkg::STATUS_OFF) ? status_word :
      hit(paddr, pump_pkg::INT_STAT_OFF) ? {29'h0, int_stat_reg} :
      hit(paddr, pump_pkg::INT_MASK_OFF) ? {29'h0, int_mask_reg} :
      hit(paddr, pump_pkg::FLOW_OFF) ? {16'h0, flow_setpoint} :
      hit(paddr, pump_pkg::FREQ_OFF) ? {16'h0, freq_hz_reg} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      head10_reg <= 1'b0;
      int_stat_reg <= 3'h0;
      int_mask_reg <= pump_pkg::INT_MASK_RESET;
      irq <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup && !pwrite ? rd_mux : 32'h0;
      if (wr_en && hit(paddr, pump_pkg::CTRL_OFF)) begin
        head10_reg <= pwdata[pump_pkg::CTRL_HEAD10_BIT];
      end
      if (wr_en && hit(paddr, pump_pkg::INT_MASK_OFF)) begin
        int_mask_reg <= pwdata[2:0];
      end
      int_stat_reg <= int_stat_next;
      irq <= |(int_stat_next & int_mask_reg);
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_run <= 1'b0;
      relay_coil <= 1'b0;
      display_select <= 1'b0;
      display_freq <= 1'b0;
      remote_flow_active <= 1'b0;
      flow_setpoint <= pump_pkg::FLOW_RESET;
    end else begin
      motor_run <= motor_next;
      relay_coil <= fault_evt || (fault_reg && !fault_clr);
      display_select <= state_next == pump_pkg::ST_SELECT;
      display_freq <= freq_mode_reg;
      remote_flow_active <= remote;
      flow_setpoint <= flow_next;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_fault_relay: assert property (@(posedge pclk) disable iff (!presetn)
    fault_evt |=> relay_coil && !motor_run) else $error("relay not set on fault");
  a_fault_stop: assert property (@(posedge pclk) disable iff (!presetn)
    motor_reg && fault_motor_stall |=> !motor_reg ##1 !motor_run)
    else $error("stall did not stop pump");
  a_start_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(motor_reg) |-> $past(run_fire || key_toggle || level_mode))
    else $error("pump started without cause");
  a_stop_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    stop_fire && !level_mode |=> !motor_reg) else $error("stop pulse ignored");
  a_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
    level_mode && !run_low |=> !motor_reg) else $error("level mode not stopping");
  a_panel_flow: assert property (@(posedge pclk) disable iff (!presetn)
    !remote |=> flow_setpoint == $past(panel_flow_reg)) else $error("panel flow not used");
  a_remote_keys: assert property (@(posedge pclk) disable iff (!presetn)
    remote && up_press |=> $stable(panel_flow_reg)) else $error("panel key in remote");
  a_sel_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    selecting && dn_press |=> freq_mode_reg != $past(freq_mode_reg))
    else $error("mode not toggled");
  a_sel_exit: assert property (@(posedge pclk) disable iff (!presetn)
    selecting && rs_press |=> normal && $stable(freq_mode_reg) ##1 !display_select)
    else $error("selection not left");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("no ready after setup");
  a_run_start: assert property (@(posedge pclk) disable iff (!presetn)
    run_fire && !stop_fire && !level_mode && !fault_evt |=> motor_reg)
    else $error("run pulse ignored");
  a_level_run: assert property (@(posedge pclk) disable iff (!presetn)
    level_mode && run_low && !fault_reg && !fault_evt |=> motor_reg)
    else $error("level mode not running");
endmodule : remote_pump_run_control
`default_nettype wire

// [core/pump_pkg.sv]
package pump_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MIN_PULSE_MS = 500;
  localparam int unsigned MIN_PULSE_CYC = MIN_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned LEVEL_HOLD_MS = 2000;
  localparam int unsigned LEVEL_HOLD_CYC = LEVEL_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned GATE_MS = 1000;
  localparam int unsigned GATE_CYC = GATE_MS * (CLK_HZ / 1000);
  localparam logic [3:0] SETTLE_CYC = 4'h8;
  // ----------------------------------------
  // Flow scaling, in uL/min
  // ----------------------------------------
  localparam logic [15:0] FULL_5ML = 16'h1388;
  localparam logic [15:0] FULL_10ML = 16'h2710;
  localparam logic [15:0] FLOW_STEP = 16'h000a;
  localparam logic [15:0] FLOW_RESET = 16'h03e8;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] INT_STAT_OFF = 8'h08;
  localparam logic [7:0] INT_MASK_OFF = 8'h0c;
  localparam logic [7:0] FLOW_OFF = 8'h10;
  localparam logic [7:0] FREQ_OFF = 8'h14;
  localparam int CTRL_HEAD10_BIT = 0;
  localparam int EV_FAULT_BIT = 0;
  localparam int EV_START_BIT = 1;
  localparam int EV_STOP_BIT = 2;
  localparam logic [2:0] INT_MASK_RESET = 3'h0;
  // Synchroniser order: key_rs, key_up, key_dn, pulse, sel_n, stop_n, run_n
  localparam logic [6:0] PIN_IDLE = 7'h07;
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b001,
    ST_SELECT = 3'b010,
    ST_NORMAL = 3'b100
  } mode_state_type;
endpackage : pump_pkg

// [core/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  // A change counts only once stages two and three agree
  wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
      pin_out <= IDLE;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_out <= (agree & s3_reg) | (~agree & pin_out);
    end
  end
endmodule : pin_sync
`default_nettype wire

// [tb/pump_remote_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pump_remote_model (
  input wire logic pclk,
  output logic run_n,
  output logic stop_n,
  output logic sel_n,
  output logic pulse
);
  int half;
  int cnt;
  // ----------------------------------------
  // Contact lines idle released, pulled up
  // ----------------------------------------
  initial begin
    run_n = 1'b1;
    stop_n = 1'b1;
    sel_n = 1'b1;
    pulse = 1'b0;
    half = 0;
  end
  // Which: 0 run, 1 stop, 2 remote select
  task automatic set_pin(input int which, input logic v);
    case (which)
      0: run_n <= v;
      1: stop_n <= v;
      default: sel_n <= v;
    endcase
  endtask : set_pin
  task automatic pulse_low(input int which, input int cyc);
    set_pin(which, 1'b0);
    repeat (cyc) @(posedge pclk);
    set_pin(which, 1'b1);
    @(posedge pclk);
  endtask : pulse_low
  // ----------------------------------------
  // Square wave source, half period in cycles
  // ----------------------------------------
  always @(posedge pclk) begin
    if (half == 0) begin
      pulse <= 1'b0;
      cnt <= 0;
    end else if (cnt >= half - 1) begin
      pulse <= ~pulse;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pump_remote_model
`default_nettype wire

// [tb/remote_pump_run_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module remote_pump_run_control_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, run_n, stop_n, sel_n, pulse;
  logic key_down = 1'b0, key_up = 1'b0, key_runstop = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic f_high = 1'b0, f_low = 1'b0, f_stall = 1'b0;
  logic motor_run, relay_coil, display_select, display_freq, remote_flow_active, irq;
  logic [15:0] flow_setpoint;
  int bad_count = 0, total_checks = 0, cycles = 0;
  always #5 pclk = ~pclk;
  pump_remote_model i_model (.pclk(pclk), .run_n(run_n), .stop_n(stop_n), .sel_n(sel_n),
    .pulse(pulse));
  remote_pump_run_control #(.MIN_PULSE_CYC(20), .LEVEL_HOLD_CYC(60), .GATE_CYC(100)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_req_n(run_n), .stop_req_n(stop_n), .remote_sel_n(sel_n), .flow_pulse_input(pulse),
    .key_down(key_down), .key_up(key_up), .key_runstop(key_runstop), .adc_code(adc_code),
    .fault_pressure_high(f_high), .fault_pressure_low(f_low), .fault_motor_stall(f_stall),
    .motor_run(motor_run), .relay_coil(relay_coil), .display_select(display_select),
    .display_freq(display_freq), .remote_flow_active(remote_flow_active),
    .flow_setpoint(flow_setpoint), .irq(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // Sampled at the falling edge so registered outputs have settled
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic check_out(input int sel, input logic [31:0] exp, input string what);
    @(negedge pclk);
    case (sel)
      0: check({31'h0, motor_run}, exp, what);
      1: check({31'h0, relay_coil}, exp, what);
      2: check({31'h0, irq}, exp, what);
      3: check({16'h0, flow_setpoint}, exp, what);
      4: check({30'h0, display_select, display_freq}, exp, what);
      default: check({31'h0, remote_flow_active}, exp, what);
    endcase
    @(posedge pclk);
  endtask : check_out
  task automatic check_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    total_checks++;
    if (got < lo || got > hi || $isunknown(got)) begin
      bad_count++;
      $display("BAD %0t flow %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : check_rng
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits until pready is high; the run timeout ends it if pready never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic press(input int k);
    if (k == 0) key_down <= 1'b1; else if (k == 1) key_up <= 1'b1; else key_runstop <= 1'b1;
    cyc(6);
    key_down <= 1'b0;
    key_up <= 1'b0;
    key_runstop <= 1'b0;
    cyc(6);
  endtask : press
  task automatic do_reset();
    presetn <= 1'b0;
    cyc(6);
    presetn <= 1'b1;
    cyc(2);
  endtask : do_reset
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check_out(3, 32'h3e8, "reset flow");
    check_out(1, 32'h0, "reset relay");
    apb(1'b0, pump_pkg::INT_MASK_OFF, 32'h0);
    check(rd, 32'h0, "mask reset");
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, pump_pkg::INT_MASK_OFF, 32'h7);
  endtask : t_reset
  task automatic t_pulse();
    i_model.pulse_low(0, 10);
    cyc(30);
    check_out(0, 32'h0, "short run rejected");
    i_model.pulse_low(0, 30);
    check_out(0, 32'h1, "run pulse starts");
    check_out(2, 32'h1, "start irq");
    apb(1'b0, pump_pkg::INT_STAT_OFF, 32'h0);
    check(rd & 32'h2, 32'h2, "start event");
    apb(1'b1, pump_pkg::INT_STAT_OFF, 32'h7);
    check_out(2, 32'h0, "irq cleared");
    i_model.pulse_low(1, 30);
    check_out(0, 32'h0, "stop pulse stops");
    apb(1'b1, pump_pkg::INT_STAT_OFF, 32'h7);
  endtask : t_pulse
  task automatic t_fault();
    i_model.pulse_low(0, 30);
    f_high <= 1'b1;
    cyc(3);
    check_out(0, 32'h0, "fault stops");
    check_out(1, 32'h1, "relay energised");
    apb(1'b0, pump_pkg::STATUS_OFF, 32'h0);
    check(rd & 32'h700, 32'h100, "fault cause high");
    apb(1'b0, pump_pkg::INT_STAT_OFF, 32'h0);
    check(rd & 32'h1, 32'h1, "fault event");
    f_high <= 1'b0;
    i_model.pulse_low(0, 30);
    check_out(1, 32'h0, "relay released on start");
    f_stall <= 1'b1;
    cyc(3);
    check_out(1, 32'h1, "stall relay");
    apb(1'b0, pump_pkg::STATUS_OFF, 32'h0);
    check(rd & 32'h700, 32'h400, "fault cause stall");
    f_stall <= 1'b0;
    i_model.pulse_low(0, 30);
    f_low <= 1'b1;
    cyc(3);
    check_out(1, 32'h1, "low pressure relay");
    apb(1'b0, pump_pkg::STATUS_OFF, 32'h0);
    check(rd & 32'h700, 32'h200, "fault cause low");
    f_low <= 1'b0;
    apb(1'b1, pump_pkg::INT_STAT_OFF, 32'h7);
  endtask : t_fault
  task automatic t_volt();
    press(1);
    check_out(3, 32'h3f2, "panel step");
    press(0);
    check_out(3, 32'h3e8, "panel step down");
    i_model.set_pin(2, 1'b0);
    adc_code <= 12'h800;
    cyc(10);
    check_out(3, 32'h9c4, "half span 5 mL");
    check_out(5, 32'h1, "remote active");
    press(1);
    check_out(3, 32'h9c4, "up key ignored");
    apb(1'b1, pump_pkg::CTRL_OFF, 32'h1);
    cyc(4);
    check_out(3, 32'h1388, "half span 10 mL");
    apb(1'b0, pump_pkg::FLOW_OFF, 32'h0);
    check(rd, 32'h1388, "flow register");
    press(2);
    check_out(0, 32'h1, "runstop key in remote");
    i_model.pulse_low(1, 30);
    check_out(0, 32'h0, "stop pin in remote");
    apb(1'b1, pump_pkg::CTRL_OFF, 32'h0);
    i_model.set_pin(2, 1'b1);
  endtask : t_volt
  task automatic t_level();
    i_model.set_pin(1, 1'b0);
    cyc(80);
    i_model.set_pin(0, 1'b0);
    cyc(10);
    check_out(0, 32'h1, "level run");
    i_model.set_pin(0, 1'b1);
    cyc(10);
    check_out(0, 32'h0, "level stop");
    i_model.set_pin(1, 1'b1);
  endtask : t_level
  task automatic t_select();
    key_down <= 1'b1;
    do_reset();
    cyc(20);
    key_down <= 1'b0;
    cyc(6);
    check_out(4, 32'h2, "select entered, U");
    press(0);
    check_out(4, 32'h3, "toggled to F");
    press(2);
    check_out(4, 32'h1, "normal, F kept");
    check_out(0, 32'h0, "exit does not run");
    i_model.set_pin(2, 1'b0);
    i_model.half = 5;
    cyc(350);
    @(negedge pclk);
    check_rng(flow_setpoint, 16'h0009, 16'h000b);
    @(posedge pclk);
    apb(1'b0, pump_pkg::FREQ_OFF, 32'h0);
    check_rng(rd[15:0], 16'h0009, 16'h000b);
    i_model.set_pin(2, 1'b1);
    cyc(6);
    check_out(3, 32'h3e8, "panel flow back");
    i_model.half = 0;
  endtask : t_select
  // ----------------------------------------
  // Run control and verdict
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  // Ceiling well above the roughly 900 cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("BAD %0t run did not complete", $time);
      finish_test();
    end
  end
  initial begin
    do_reset();
    t_reset();
    t_pulse();
    t_fault();
    t_volt();
    t_level();
    t_select();
    finish_test();
  end
endmodule : remote_pump_run_control_tb
`default_nettype wire
